/* File: src/eif_pkg.sv */
/*
 Package for the external interrupt input filter: control register map,
 field positions, reset value and noise rejection counts.
 Assumes a 10 MHz high-frequency clock and an 8-bit register port.
*/
package eif_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [15:0] EIF_CTRL_ADDR = 16'h0037;
   localparam logic [7:0] EIF_CTRL_RESET = 8'h00;
   localparam int EIF_NC1_BIT = 7;   // Noise window select, input one
   localparam int EIF_PFS0_BIT = 6;  // Pin function select, input zero
   localparam int EIF_ES3_BIT = 3;
   localparam int EIF_ES2_BIT = 2;
   localparam int EIF_ES1_BIT = 1;
   localparam logic [7:0] EIF_CTRL_MASK = 8'hce;

   // ----------------------------------------------------------------
   // Sources and timing
   // ----------------------------------------------------------------
   localparam int EIF_NSRC = 5;     // Index 0..4 = inputs 0,1,2,3,5
   localparam int EIF_CW = 7;
   // Rejection windows in high-frequency clock periods
   localparam logic [6:0] EIF_REJ_ZF = 7'h02;   // Inputs zero and five
   localparam logic [6:0] EIF_REJ_ONE_L = 7'h3f;  // Input one, window sel 0
   localparam logic [6:0] EIF_REJ_ONE_S = 7'h0f;  // Input one, window sel 1
   localparam logic [6:0] EIF_REJ_TT = 7'h07;   // Inputs two and three
   // Slow mode: two consecutive low-frequency samples
   localparam logic [6:0] EIF_REJ_SLOW = 7'h02;
   // Latch set latency bound beyond qualification, in fc periods
   localparam int EIF_LAT_EXTRA = 6;
endpackage

/* File: src/eif_sync.sv */
/*
 Two-stage synchroniser for one interrupt pin.
 Assumes the pin idles high; the stages reset to one.
*/
`timescale 1ns/1ps
module eif_sync
   import eif_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic pin,
   output logic pin_sync
);
   logic meta;

   // ----------------------------------------------------------------
   // Synchroniser; first stage feeds only the second
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= 1'b1;
         pin_sync <= 1'b1;
      end
      else
      begin
         meta <= pin;
         pin_sync <= meta;
      end
   end
endmodule

/* File: src/eif_filter.sv */
/*
 Digital noise rejection filter for one synchronised pin.
 Assumes lf_tick is a one-cycle enable at the low-frequency clock rate.
*/
`timescale 1ns/1ps
module eif_filter
   import eif_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic pin_sync,
   input wire logic slow_mode,
   input wire logic lf_tick,
   input wire logic [6:0] fast_window,
   output logic level,
   output logic rise,
   output logic fall
);
   logic [6:0] cnt;
   wire step = !slow_mode || lf_tick;
   wire [6:0] window = slow_mode ? EIF_REJ_SLOW : fast_window;
   wire [6:0] cnt_inc = cnt + 7'h01;
   wire differs = pin_sync != level;
   wire accept = differs && step && (cnt_inc >= window);

   // ----------------------------------------------------------------
   // Level follows pin only after it held for the full window
   // ----------------------------------------------------------------
   // A window change takes effect on the next compare, well inside 2^6 fc
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt <= 7'h00;
         level <= 1'b1;
         rise <= 1'b0;
         fall <= 1'b0;
      end
      else
      begin
         rise <= accept && pin_sync;   // RQ1
         fall <= accept && !pin_sync;  // RQ1
         if (!differs || accept)
            cnt <= 7'h00;
         else if (step)
            cnt <= cnt_inc;            // RQ5 RQ6 RQ7 RQ8
         if (accept)
            level <= pin_sync;         // RQ14
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_count_bound: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ1
      cnt < window || $changed(window))
      else $error("filter count ran past its window");
   chk_slow_tick: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ8
      $changed(level) && $past(slow_mode) |-> $past(lf_tick))
      else $error("slow filter moved without a low-frequency tick");
   chk_min_width: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ5
      $changed(level) && !$past(slow_mode) |-> $past(pin_sync, 2) == $past(pin_sync))
      else $error("filter accepted a single-cycle pulse");
   chk_edge_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ18
      $fell(level) |-> fall && !rise)
      else $error("falling edge pulse missing");
endmodule

/* File: src/eif_top.sv */
/*
 External interrupt input filter: five pin inputs, per-pin noise filters,
 edge selection, the control register and the five interrupt latches.
 Assumes pins are asynchronous, the register port is the SFR strobe port
 of the core, and acceptance pulses come from the CPU sequencer.
*/
// Operation
// [RQ1] Five external inputs, each with its own noise rejection filter.
// [RQ2] Inputs one to three pick edge polarity; zero and five falling only.
// [RQ3] Shared pin zero leaves reset as a port bit, not an interrupt.
// [RQ4] With function select 0, falling edges on pin zero never set its latch; here one still in its filter when the select goes to 1 sets it.
// [RQ5] Fast mode: inputs zero, five reject under 2, accept 7 periods.
// [RQ6] Fast mode: input one rejects under 15 or 63, accepts 49 or 193.
// [RQ7] Fast mode: inputs two, three reject under 7, accept 25 periods.
// [RQ8] Slow and sleep: reject under one low period, accept 3.5.
// [RQ9] Input one window select: 0 gives 63 periods, 1 gives 15.
// [RQ10] Edge select 0 means rising edge, 1 means falling edge.
// [RQ11] Function select 0 is port bit, 1 is interrupt; software sets input.
// [RQ12] Clean edge sets latch within qualification time plus 6 periods.
// [RQ13] Pin data or direction changes may fake requests; software masks.
// [RQ14] New input one window in force within 2^6 periods of write.
// [RQ15] Software masks interrupts while switching clocks or rewriting control.
// [RQ16] Software avoids read-modify-write on latches and write-only registers.
// [RQ17] Acceptance clears the accepted source's latch.
// [RQ18] Pins are synchronised before measuring and edge detection.
// [RQ19] Latch holds until accepted; request needs master and own enable.
`timescale 1ns/1ps
module eif_top
   import eif_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ext_irq_zero,
   input wire logic ext_irq_one,
   input wire logic ext_irq_two,
   input wire logic ext_irq_three,
   input wire logic ext_irq_five,
   input wire logic slow_mode,
   input wire logic lf_tick,
   input wire logic [15:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_hit,
   input wire logic master_irq_enable_flag,
   input wire logic [4:0] interrupt_enable_register,
   input wire logic [4:0] irq_accept,
   output logic [4:0] interrupt_latch,
   output logic [4:0] irq_request,
   output logic irq_zero_pin_function_sel
);
   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   logic [7:0] external_interrupt_control;
   wire ctrl_sel = sfr_addr == EIF_CTRL_ADDR;
   wire ctrl_wr = sfr_wr && ctrl_sel;
   wire [7:0] next_ctrl = sfr_wdata & EIF_CTRL_MASK;
   wire irq_one_noise_window_sel = external_interrupt_control[EIF_NC1_BIT];
   wire pfs_zero = external_interrupt_control[EIF_PFS0_BIT];
   wire irq_one_edge_sel = external_interrupt_control[EIF_ES1_BIT];
   wire irq_two_edge_sel = external_interrupt_control[EIF_ES2_BIT];
   wire irq_three_edge_sel = external_interrupt_control[EIF_ES3_BIT];

   // Reset value clears the function select so the pin starts as a port
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         external_interrupt_control <= EIF_CTRL_RESET;   // RQ3
      else if (ctrl_wr)
         external_interrupt_control <= next_ctrl;        // RQ11
   end

   // Read data registered; unused bits read as zero
   wire [7:0] next_rdata = (sfr_rd && ctrl_sel) ? external_interrupt_control : 8'h00;
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sfr_rdata <= 8'h00;
         sfr_hit <= 1'b0;
         irq_zero_pin_function_sel <= 1'b0;
      end
      else
      begin
         sfr_rdata <= next_rdata;
         sfr_hit <= (sfr_rd || sfr_wr) && ctrl_sel;
         irq_zero_pin_function_sel <= ctrl_wr ? next_ctrl[EIF_PFS0_BIT] : pfs_zero;
      end
   end

   // ----------------------------------------------------------------
   // Per-source windows and edge choice
   // ----------------------------------------------------------------
   // Window select 0 gives the long window
   wire [6:0] win_one = irq_one_noise_window_sel ? EIF_REJ_ONE_S : EIF_REJ_ONE_L; // RQ9
   wire [4:0] pins = {ext_irq_five, ext_irq_three, ext_irq_two, ext_irq_one, ext_irq_zero};
   wire [6:0] windows [EIF_NSRC];
   assign windows[0] = EIF_REJ_ZF;    // RQ5
   assign windows[1] = win_one;       // RQ6
   assign windows[2] = EIF_REJ_TT;    // RQ7
   assign windows[3] = EIF_REJ_TT;    // RQ7
   assign windows[4] = EIF_REJ_ZF;    // RQ5
   // Edge select 1 = falling; zero and five are fixed falling
   wire [4:0] use_fall = {1'b1, irq_three_edge_sel, irq_two_edge_sel,
                          irq_one_edge_sel, 1'b1};  // RQ2 RQ10

   // ----------------------------------------------------------------
   // Synchronisers and filters
   // ----------------------------------------------------------------
   wire [4:0] pin_sync;
   wire [4:0] lvl;
   wire [4:0] rise;
   wire [4:0] fall;
   genvar g;
   generate
      for (g = 0; g < EIF_NSRC; g++)
      begin : g_src
         eif_sync u_sync (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .pin(pins[g]),
            .pin_sync(pin_sync[g])
         );  // RQ18
         eif_filter u_filt (
            .ref_clk(ref_clk),
            .rst_n(rst_n),
            .pin_sync(pin_sync[g]),
            .slow_mode(slow_mode),
            .lf_tick(lf_tick),
            .fast_window(windows[g]),
            .level(lvl[g]),
            .rise(rise[g]),
            .fall(fall[g])
         );  // RQ1 RQ8
      end
   endgenerate

   // ----------------------------------------------------------------
   // Interrupt latches and requests
   // ----------------------------------------------------------------
   // Source zero only counts while its pin is in interrupt function
   // Port-mode edges on pin zero are dropped, but one still in its filter when the select goes to 1 can set the latch
   wire [4:0] src_gate = {4'hf, pfs_zero};                                 // RQ4 RQ13
   wire [4:0] qual_edge = ((fall & use_fall) | (rise & ~use_fall)) & src_gate; // RQ2
   // A set in the same cycle as an accept wins, so no edge is lost
   wire [4:0] next_latch = (interrupt_latch & ~irq_accept) | qual_edge;   // RQ17 RQ19
   wire [4:0] next_request = master_irq_enable_flag ?
                             (next_latch & interrupt_enable_register) : 5'h00; // RQ19

   // Latches set two fc after the filter accepts, within the 6 fc margin
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         interrupt_latch <= 5'h00;
         irq_request <= 5'h00;
      end
      else
      begin
         interrupt_latch <= next_latch;   // RQ12
         irq_request <= next_request;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_reset_port: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ3
      $rose(pfs_zero) |-> $past(ctrl_wr) && $past(sfr_wdata[EIF_PFS0_BIT]))
      else $error("pin zero became interrupt without a write");
   chk_zero_gated: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ4
      fall[0] && !pfs_zero && !interrupt_latch[0] |=> !interrupt_latch[0])
      else $error("latch zero set while pin is a port bit");
   chk_edge_polarity: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ10
      $rose(interrupt_latch[1]) |->
         $past(irq_one_edge_sel ? fall[1] : rise[1]))
      else $error("input one latched on the wrong edge");
   chk_latch_set: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ12
      $fell(lvl[4]) |=> interrupt_latch[4])
      else $error("input five edge did not set its latch in time");
   chk_accept_clear: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ17
      irq_accept[2] && !qual_edge[2] |=> !interrupt_latch[2])
      else $error("accepted latch not cleared");
   chk_latch_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ19
      interrupt_latch[3] && !irq_accept[3] |=> interrupt_latch[3])
      else $error("latch dropped without acceptance");
   chk_request_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ19
      irq_request[1] |-> $past(master_irq_enable_flag)
         && $past(interrupt_enable_register[1]) && interrupt_latch[1])
      else $error("request without enables and latch");
   chk_window_one: assert property (@(posedge ref_clk) disable iff (!rst_n) // RQ9
      windows[1] == (irq_one_noise_window_sel ? 7'h0f : 7'h3f))
      else $error("input one window does not follow its select");
endmodule

/* File: tb/eif_pin_src.sv */
/*
 Pin source model: five idle-high external interrupt pins.
 Assumes one bench process calls drive() at a time.
*/
`timescale 1ns/1ps
module eif_pin_src
(
   input wire logic ref_clk,
   output logic [4:0] pins
);
   // Pins rest high, as a pulled-up undriven line would
   initial pins = 5'h1f;

   // Level changes just after an edge, then held for cyc clock periods
   task automatic drive(input int idx, input logic lvl, input int cyc);
      @(posedge ref_clk);
      #1 pins[idx] = lvl;
      repeat (cyc - 1) @(posedge ref_clk);
   endtask
endmodule

/* File: tb/eif_top_bench.sv */
/*
 Self-checking bench for the interrupt input filter: pulse widths per
 window, edge polarity, pin function, slow mode and latch clearing.
 Assumes a 100 ns clock and a 1 ns drive delay after each edge.
*/
`timescale 1ns/1ps
module eif_top_bench
   import eif_pkg::*;
;
   logic ref_clk, rst_n, slow_mode, lf_tick, sfr_wr, sfr_rd, sfr_hit;
   logic master_irq_enable_flag, irq_zero_pin_function_sel;
   logic [15:0] sfr_addr;
   logic [7:0] sfr_wdata, sfr_rdata;
   logic [4:0] pins, interrupt_enable_register, irq_accept, interrupt_latch, irq_request;
   logic [31:0] r;
   int seed = 35;
   int bad_count = 0;
   int n_checks = 0;
   int exp_latch = 0;

   eif_pin_src eif_pin_src_inst (.ref_clk(ref_clk), .pins(pins));

   eif_top eif_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ext_irq_zero(pins[0]),
      .ext_irq_one(pins[1]), .ext_irq_two(pins[2]), .ext_irq_three(pins[3]),
      .ext_irq_five(pins[4]), .slow_mode(slow_mode), .lf_tick(lf_tick),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
      .master_irq_enable_flag(master_irq_enable_flag),
      .interrupt_enable_register(interrupt_enable_register), .irq_accept(irq_accept),
      .interrupt_latch(interrupt_latch), .irq_request(irq_request),
      .irq_zero_pin_function_sel(irq_zero_pin_function_sel));

   // ----------------------------------------------------------------
   // Clock, low-frequency tick every 8 clocks, watchdog
   // ----------------------------------------------------------------
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   initial
   begin
      lf_tick = 1'b0;
      forever
      begin
         repeat (7) @(posedge ref_clk);
         #1 lf_tick = 1'b1;
         @(posedge ref_clk);
         #1 lf_tick = 1'b0;
      end
   end

   // The whole run needs about 2300 clocks; a hang ends well beyond that
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      stop_test();
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic stop_test();
      if (bad_count == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Request is the latch gated by both enables
   task automatic check_latch();
      logic [4:0] exp_req;
      exp_req = exp_latch[4:0] & interrupt_enable_register & {5{master_irq_enable_flag}};
      check("interrupt_latch", {3'h0, exp_latch[4:0]}, {3'h0, interrupt_latch});
      check("irq_request", {3'h0, exp_req}, {3'h0, irq_request});
   endtask

   task automatic wr(input logic [15:0] addr, input logic [7:0] data);
      @(posedge ref_clk);
      #1 sfr_addr = addr;
      sfr_wdata = data;
      sfr_wr = 1'b1;
      @(posedge ref_clk);
      #1 sfr_wr = 1'b0;
   endtask

   task automatic rd_check(input logic [15:0] addr, input logic [7:0] exp, input logic hit);
      @(posedge ref_clk);
      #1 sfr_addr = addr;
      sfr_rd = 1'b1;
      @(posedge ref_clk);
      #1 sfr_rd = 1'b0;
      check("sfr_rdata", exp, sfr_rdata);
      check("sfr_hit", {7'h0, hit}, {7'h0, sfr_hit});
   endtask

   task automatic accept_all();
      @(posedge ref_clk);
      #1 irq_accept = 5'h1f;
      @(posedge ref_clk);
      #1 irq_accept = 5'h00;
      exp_latch = 0;
      check_latch();
   endtask

   // Low pulse with random enables; long settle so any edge has landed
   task automatic pulse(input int idx, input int width, input bit qual);
      @(posedge ref_clk);
      #1 r = $random(seed);
      master_irq_enable_flag = r[0];
      interrupt_enable_register = r[5:1];
      eif_pin_src_inst.drive(idx, 1'b0, width);
      eif_pin_src_inst.drive(idx, 1'b1, 90);
      #1 if (qual)
         exp_latch = exp_latch | (1 << idx);
      check_latch();
      accept_all();
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      slow_mode = 1'b0;
      sfr_addr = 16'h0000;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
      master_irq_enable_flag = 1'b1;
      interrupt_enable_register = 5'h1f;
      irq_accept = 5'h00;
      repeat (4) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      rd_check(16'h0037, 8'h00, 1'b1);
      check("pin_function_sel", 8'h00, {7'h0, irq_zero_pin_function_sel});
      pulse(0, 20, 0);
      rd_check(16'h0036, 8'h00, 1'b0);
      r = $random(seed);
      wr(16'h0037, r[7:0]);
      rd_check(16'h0037, r[7:0] & 8'hce, 1'b1);
      wr(16'h0037, 8'h4e);
      check("pin_function_sel", 8'h01, {7'h0, irq_zero_pin_function_sel});
      pulse(0, 1, 0);
      pulse(0, 7, 1);
      pulse(4, 1, 0);
      pulse(4, 7, 1);
      pulse(2, 6, 0);
      pulse(2, 25, 1);
      pulse(3, 6, 0);
      pulse(3, 25, 1);
      pulse(1, 62, 0);
      pulse(1, 193, 1);
      // Narrow window must hold for the very next pulse after the write
      wr(16'h0037, 8'hce);
      pulse(1, 14, 0);
      pulse(1, 49, 1);
      // Rising select: no set while low, set within window plus 6 of release
      wr(16'h0037, 8'hc0);
      for (int i = 1; i < 4; i++)
      begin
         eif_pin_src_inst.drive(i, 1'b0, 40);
         #1 check_latch();
         eif_pin_src_inst.drive(i, 1'b1, (i == 1) ? 22 : 14);
         #1 exp_latch = 1 << i;
         check_latch();
         accept_all();
      end
      // Pins rest idle while the clock mode changes
      slow_mode = 1'b1;
      pulse(4, 5, 0);
      pulse(4, 28, 1);
      pulse(2, 5, 0);
      pulse(2, 28, 1);
      stop_test();
   end
endmodule
